//--- hdl/host_port_params.svh
// Offsets, reset values, field positions and timing figures of the host port.
// Included by the host port and the bench; definitions only.
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets (9-bit host address)
// ------------------------------------------------------------
`define OFS_SCRATCH 9'h000
`define OFS_GPIO_DIR 9'h001
`define OFS_GPIO_OUT 9'h002
`define OFS_GPIO_IN 9'h003
`define OFS_INT_PEND 9'h004
`define OFS_INT_MASK 9'h005
`define OFS_PM_CTRL 9'h006
`define OFS_DEV_ID 9'h007

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_SCRATCH 8'h00
`define RST_GPIO_DIR 8'h00
`define RST_GPIO_OUT 8'h00
`define RST_INT_MASK 8'h00
`define RST_PM_CTRL 8'h00
// Arbitrary value, not tied to any part
`define DEV_ID_VALUE 8'h5A

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PM_CTRL_OUT_EN 0
`define PM_CTRL_IN_SEL 1
`define INT_TICK_BIT 7

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define REF_CLK_PERIOD_NS 4
`define PM_TICK_PERIOD_US 1000

`endif

//--- hdl/host_port_pkg.sv
// Types shared by the host port: synchronised pin bundle, access states, state.
// Assumes host_port_params.svh is on the include path.
`default_nettype none
package host_port_pkg;

	// ------------------------------------------------------------
	// Pin bundle sampled from the host side
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic [8:0] addr;
		logic ale;
		logic chip_select_n;
		logic write_strobe_n;
		logic read_strobe_n;
		logic oe;
		logic tick;
		logic [7:0] gpio;
	} pin_t;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WRITE = 2'b01,
		ACC_READ = 2'b10
	} acc_t;

	typedef struct packed {
		pin_t s1;
		pin_t s2;
		pin_t s3;
		pin_t filt;
		acc_t acc;
		logic [8:0] addr_lat;
		logic [7:0] scratch;
		logic [7:0] gpio_dir;
		logic [7:0] gpio_out;
		logic [7:0] int_pend;
		logic [7:0] int_mask;
		logic [7:0] pm_ctrl;
		logic [31:0] tick_cnt;
		logic [7:0] data_out;
		logic data_oe;
		logic int_oe;
		logic tick_out;
		logic tick_oe;
		logic [7:0] gpio_o;
		logic [7:0] gpio_oe;
		logic perf_latch;
	} state_t;

endpackage

`default_nettype wire

//--- hdl/host_port.sv
// Asynchronous 8-bit host register port with interrupt, tick and GPIO pins.
// Assumes every host pin is asynchronous to i_ref_clk; i_int_event is on-clock.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_params.svh"

module host_port
	import host_port_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = (`PM_TICK_PERIOD_US * 1000) / `REF_CLK_PERIOD_NS
) (
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe,
	input wire logic [8:0] i_addr,
	input wire logic i_ale,
	input wire logic i_chip_select_n,
	input wire logic i_write_strobe_n,
	input wire logic i_read_strobe_n,
	input wire logic i_oe,
	output logic o_interrupt_out_n,
	output logic o_interrupt_out_n_oe,
	input wire logic [6:0] i_int_event,
	input wire logic i_perf_monitor_tick,
	output logic o_perf_monitor_tick,
	output logic o_perf_monitor_tick_oe,
	output logic o_perf_latch,
	input wire logic [7:0] i_gpio,
	output logic [7:0] o_gpio,
	output logic [7:0] o_gpio_oe
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// nine-bit offset decode
	function automatic logic [7:0] read_reg(input state_t s, input logic [8:0] a);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`OFS_SCRATCH: v = s.scratch;
			`OFS_GPIO_DIR: v = s.gpio_dir;
			`OFS_GPIO_OUT: v = s.gpio_out;
			`OFS_GPIO_IN: v = s.filt.gpio;
			`OFS_INT_PEND: v = s.int_pend;
			`OFS_INT_MASK: v = s.int_mask;
			`OFS_PM_CTRL: v = s.pm_ctrl;
			`OFS_DEV_ID: v = `DEV_ID_VALUE;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Agreeing stages take effect, a disagreement keeps the last value
	function automatic pin_t filter(input pin_t a, input pin_t b, input pin_t prev);
		return (a & b) | (prev & (a ^ b));
	endfunction

	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

	state_t q;
	state_t d;
	pin_t pins;
	logic wr_act;
	logic rd_act;
	logic wr_fire;
	logic tick_fire;
	logic tick_rise;
	logic out_en;
	logic in_sel;

	assign pins = '{data: i_data, addr: i_addr, ale: i_ale, chip_select_n: i_chip_select_n,
		write_strobe_n: i_write_strobe_n, read_strobe_n: i_read_strobe_n, oe: i_oe,
		tick: i_perf_monitor_tick, gpio: i_gpio};

	assign wr_act = !q.filt.chip_select_n && !q.filt.write_strobe_n;
	assign rd_act = !q.filt.chip_select_n && !q.filt.read_strobe_n;
	assign wr_fire = wr_act && (q.acc == ACC_IDLE);
	assign out_en = q.pm_ctrl[`PM_CTRL_OUT_EN];
	assign in_sel = q.pm_ctrl[`PM_CTRL_IN_SEL];
	assign tick_fire = (q.tick_cnt == TICK_LAST);
	assign tick_rise = !q.filt.tick && q.s2.tick && q.s3.tick;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] clr;
		logic [7:0] set;
		logic ext_latch;
		clr = 8'h00;
		set = 8'h00;
		ext_latch = 1'b0;
		d = q;
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.filt = filter(q.s2, q.s3, q.filt);

		// transparent while high, holds while low
		if (q.filt.ale) begin
			d.addr_lat = q.filt.addr;
		end

		unique case (q.acc)
			ACC_IDLE: begin
				if (wr_act) begin
					d.acc = ACC_WRITE;
				end else if (rd_act) begin
					d.acc = ACC_READ;
				end
			end
			ACC_WRITE: begin
				if (!wr_act) begin
					d.acc = ACC_IDLE;
				end
			end
			ACC_READ: begin
				if (!rd_act) begin
					d.acc = ACC_IDLE;
				end
			end
			default: begin
				d.acc = ACC_IDLE;
			end
		endcase

		if (wr_fire) begin
			unique case (q.addr_lat)
				`OFS_SCRATCH: d.scratch = q.filt.data;
				`OFS_GPIO_DIR: d.gpio_dir = q.filt.data;
				`OFS_GPIO_OUT: d.gpio_out = q.filt.data;
				`OFS_INT_PEND: clr = q.filt.data;
				`OFS_INT_MASK: d.int_mask = q.filt.data;
				`OFS_PM_CTRL: d.pm_ctrl = q.filt.data;
				default: clr = 8'h00;
			endcase
		end

		// Tick timer free-runs so the period stays fixed across mode changes
		d.tick_cnt = tick_fire ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;
		ext_latch = in_sel && !out_en && tick_rise;
		d.perf_latch = (out_en && tick_fire) || ext_latch;
		set = {d.perf_latch, i_int_event};
		// Set wins over a same-cycle clear
		d.int_pend = (q.int_pend & ~clr) | set;

		d.data_out = read_reg(q, q.addr_lat);
		d.data_oe = rd_act && q.filt.oe;
		d.int_oe = ((q.int_pend & q.int_mask) != 8'h00) && q.filt.oe;
		d.tick_out = out_en && tick_fire;
		d.tick_oe = out_en && q.filt.oe;
		d.gpio_o = q.gpio_out;
		d.gpio_oe = q.gpio_dir & {8{q.filt.oe}};
	end

	always_ff @(posedge i_ref_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			q <= '0;
			q.filt.chip_select_n <= 1'b1;
			q.filt.write_strobe_n <= 1'b1;
			q.filt.read_strobe_n <= 1'b1;
			// Idle strobes in every stage, else agreeing zeros fake an access
			q.s1.chip_select_n <= 1'b1;
			q.s1.write_strobe_n <= 1'b1;
			q.s1.read_strobe_n <= 1'b1;
			q.s2.chip_select_n <= 1'b1;
			q.s2.write_strobe_n <= 1'b1;
			q.s2.read_strobe_n <= 1'b1;
			q.s3.chip_select_n <= 1'b1;
			q.s3.write_strobe_n <= 1'b1;
			q.s3.read_strobe_n <= 1'b1;
			q.scratch <= `RST_SCRATCH;
			q.gpio_dir <= `RST_GPIO_DIR;
			q.gpio_out <= `RST_GPIO_OUT;
			q.int_mask <= `RST_INT_MASK;
			q.pm_ctrl <= `RST_PM_CTRL;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_data = q.data_out;
	assign o_data_oe = q.data_oe;
	assign o_interrupt_out_n = 1'b0;
	assign o_interrupt_out_n_oe = q.int_oe;
	assign o_perf_monitor_tick = q.tick_out;
	assign o_perf_monitor_tick_oe = q.tick_oe;
	assign o_perf_latch = q.perf_latch;
	assign o_gpio = q.gpio_o;
	assign o_gpio_oe = q.gpio_oe;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);

	sequence wr_taken;
		wr_fire && (q.addr_lat == `OFS_SCRATCH);
	endsequence

	a_reset_tristate: assert property ($rose(i_resetn) |-> !o_data_oe && !o_interrupt_out_n_oe
		&& !o_perf_monitor_tick_oe && (o_gpio_oe == 8'h00))
		else $error("output enabled right after reset");
	a_oe_tristate: assert property (!q.filt.oe |=> !o_data_oe && !o_interrupt_out_n_oe
		&& !o_perf_monitor_tick_oe && (o_gpio_oe == 8'h00))
		else $error("output enabled while output enable low");
	a_write_store: assert property (wr_taken |=> q.scratch == $past(q.filt.data))
		else $error("write data not stored");
	a_write_once: assert property (wr_fire |=> (!wr_fire)[*2])
		else $error("second update from one strobe");
	a_read_drive: assert property (rd_act && q.filt.oe |=> o_data_oe ##0
		o_data == read_reg($past(q), $past(q.addr_lat)))
		else $error("read not driven");
	a_data_float: assert property (!rd_act |=> !o_data_oe)
		else $error("data bus driven outside read");
	a_addr_hold: assert property (!q.filt.ale |=> $stable(q.addr_lat))
		else $error("latched address moved");
	a_addr_pass: assert property (q.filt.ale |=> q.addr_lat == $past(q.filt.addr))
		else $error("address not transparent");
	a_int_assert: assert property (((q.int_pend & q.int_mask) != 8'h00) && q.filt.oe
		|=> o_interrupt_out_n_oe)
		else $error("interrupt not asserted");
	a_int_release: assert property (((q.int_pend & q.int_mask) == 8'h00) |=> !o_interrupt_out_n_oe)
		else $error("interrupt not released");
	a_int_drain: assert property (o_interrupt_out_n_oe |-> !o_interrupt_out_n)
		else $error("interrupt driven high");
	a_tick_pulse: assert property (out_en && tick_fire |=> o_perf_monitor_tick && o_perf_latch
		##1 !o_perf_monitor_tick)
		else $error("tick pulse missing");
	a_tick_input: assert property (in_sel && !out_en && tick_rise
		|=> o_perf_latch)
		else $error("external tick ignored");
	a_gpio_dir: assert property (1'b1 |=> o_gpio_oe == ($past(q.gpio_dir) & {8{$past(q.filt.oe)}}))
		else $error("gpio direction wrong");

	// ------------------------------------------------------------
	// Decode, pending and pin checks
	// ------------------------------------------------------------
	sequence off_map_write;
		wr_fire && (q.addr_lat > `OFS_DEV_ID);
	endsequence

	sequence off_map_read;
		rd_act && q.filt.oe && (q.addr_lat > `OFS_DEV_ID);
	endsequence

	// Only a clear with no same-cycle set must empty the bits
	sequence pend_clear_quiet;
		wr_fire && (q.addr_lat == `OFS_INT_PEND) && (i_int_event == 7'h00) && !d.perf_latch;
	endsequence

	a_unmapped_write: assert property (off_map_write |=> $stable(q.scratch) && $stable(q.gpio_dir)
		&& $stable(q.gpio_out) && $stable(q.int_mask) && $stable(q.pm_ctrl))
		else $error("unmapped write changed a register");
	a_unmapped_read: assert property (off_map_read |=> o_data == 8'h00)
		else $error("unmapped read not zero");
	a_pend_clear: assert property (pend_clear_quiet |=> (q.int_pend & $past(q.filt.data)) == 8'h00)
		else $error("pending bit not cleared");
	a_pend_set: assert property (i_int_event != 7'h00
		|=> (q.int_pend[6:0] & $past(i_int_event)) == $past(i_int_event))
		else $error("event not recorded");
	a_tick_quiet: assert property (!out_en |=> !o_perf_monitor_tick)
		else $error("tick pulse while output off");
	a_tick_enable: assert property (1'b1
		|=> o_perf_monitor_tick_oe == ($past(out_en) && $past(q.filt.oe)))
		else $error("tick pin enable wrong");
	a_ext_ignored: assert property (tick_rise && !in_sel && !out_en |=> !o_perf_latch)
		else $error("external tick taken while not selected");
	a_gpio_value: assert property (1'b1 |=> o_gpio == $past(q.gpio_out))
		else $error("gpio output value wrong");

endmodule

`default_nettype wire

//--- tb/host_model.sv
// Host processor model driving the asynchronous register port pins.
// Assumes the bench clock only paces the model; strobes last 8 cycles.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	input wire logic i_rdata_oe,
	output logic [7:0] o_data,
	output logic [8:0] o_addr,
	output logic o_ale,
	output logic o_cs_n,
	output logic o_wr_n,
	output logic o_rd_n
);
	initial begin
		o_data = 8'h00;
		o_addr = 9'h000;
		o_ale = 1'b1;
		o_cs_n = 1'b1;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
	end

	// One byte access; lat freezes the address and then scrambles the address pins
	task automatic acc(input logic wr, input logic lat, input logic [8:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		#1 o_addr = a;
		o_data = wr ? d : ~d;
		repeat (6) @(posedge i_clk);
		#1 if (lat) begin
			o_ale = 1'b0;
			repeat (6) @(posedge i_clk);
			#1 o_addr = ~a;
		end
		o_cs_n = 1'b0;
		if (wr) o_wr_n = 1'b0;
		else o_rd_n = 1'b0;
		repeat (8) @(posedge i_clk);
		#1 q = i_rdata_oe ? i_rdata : 8'hXX;
		o_cs_n = 1'b1;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		// Released bus shows the inverse, not the old byte
		o_data = ~d;
		repeat (6) @(posedge i_clk);
		#1 o_ale = 1'b1;
	endtask
endmodule
`default_nettype wire

//--- tb/cpu_host_port_with_misc_control_tb.sv
// Self-checking bench for the host port with a host model on the pins.
// Assumes the design package and parameter header are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "host_port_params.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module cpu_host_port_with_misc_control_tb;
	logic i_ref_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_oe = 1'b1;
	logic [6:0] i_int_event = 7'h00;
	logic i_perf_monitor_tick = 1'b0;
	logic [7:0] i_gpio = 8'h00;
	wire [7:0] hd, o_data, o_gpio, o_gpio_oe;
	wire [8:0] ha;
	wire hale, hcs, hwr, hrd, o_data_oe, o_interrupt_out_n, o_interrupt_out_n_oe;
	wire o_perf_monitor_tick, o_perf_monitor_tick_oe, o_perf_latch;
	int fail_count = 0;
	int comparisons = 0;
	int n;
	int m;
	logic [7:0] q, d, e;

	always #2 i_ref_clk = ~i_ref_clk;

	host_model host_u (.i_clk(i_ref_clk), .i_rdata(o_data), .i_rdata_oe(o_data_oe), .o_data(hd),
		.o_addr(ha), .o_ale(hale), .o_cs_n(hcs), .o_wr_n(hwr), .o_rd_n(hrd));

	host_port #(.TICK_CYCLES(16)) dut_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_data(hd),
		.o_data(o_data), .o_data_oe(o_data_oe), .i_addr(ha), .i_ale(hale), .i_chip_select_n(hcs),
		.i_write_strobe_n(hwr), .i_read_strobe_n(hrd), .i_oe(i_oe),
		.o_interrupt_out_n(o_interrupt_out_n), .o_interrupt_out_n_oe(o_interrupt_out_n_oe),
		.i_int_event(i_int_event), .i_perf_monitor_tick(i_perf_monitor_tick),
		.o_perf_monitor_tick(o_perf_monitor_tick), .o_perf_monitor_tick_oe(o_perf_monitor_tick_oe),
		.o_perf_latch(o_perf_latch), .i_gpio(i_gpio), .o_gpio(o_gpio), .o_gpio_oe(o_gpio_oe));

	function automatic logic [7:0] gpio_en(input logic [7:0] dir, input logic oe);
		return dir & {8{oe}};
	endfunction

	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		logic [7:0] x;
		host_u.acc(1'b1, 1'b0, a, v, x);
	endtask

	task automatic rd(input logic [8:0] a, output logic [7:0] v);
		host_u.acc(1'b0, 1'b0, a, 8'h3C, v);
	endtask

	task automatic pulse(input logic [6:0] ev);
		@(posedge i_ref_clk);
		#1 i_int_event = ev;
		@(posedge i_ref_clk);
		#1 i_int_event = 7'h00;
		repeat (3) @(posedge i_ref_clk);
	endtask

	task automatic count(input int cyc);
		n = 0;
		m = 0;
		repeat (cyc) begin
			@(negedge i_ref_clk);
			if (o_perf_latch === 1'b1) n++;
			if (o_perf_monitor_tick === 1'b1) m++;
		end
	endtask

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge i_ref_clk);
		`CHK({o_data_oe, o_interrupt_out_n_oe, o_perf_monitor_tick_oe, o_gpio_oe}, 11'h000)
		`CHK(o_interrupt_out_n, 1'b0)
		#1 i_resetn = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		void'($urandom(32'h5f13d57f));
		rd(`OFS_DEV_ID, q);
		`CHK(q, `DEV_ID_VALUE)
		`CHK(o_data_oe, 1'b0)
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(`OFS_SCRATCH, d);
			rd(`OFS_SCRATCH, q);
			`CHK(q, d)
		end
		wr(9'h1FF, 8'hFF);
		rd(9'h1FF, q);
		`CHK(q, 8'h00)
		host_u.acc(1'b1, 1'b1, `OFS_SCRATCH, 8'hA5, q);
		rd(`OFS_SCRATCH, q);
		`CHK(q, 8'hA5)
		$display("registers done");
		d = 8'($urandom);
		e = 8'($urandom);
		i_gpio = 8'($urandom);
		wr(`OFS_GPIO_DIR, d);
		wr(`OFS_GPIO_OUT, e);
		rd(`OFS_GPIO_IN, q);
		`CHK(q, i_gpio)
		`CHK(o_gpio_oe, gpio_en(d, 1'b1))
		`CHK(o_gpio, e)
		$display("gpio done");
		wr(`OFS_INT_MASK, 8'h01);
		pulse(7'h02);
		`CHK(o_interrupt_out_n_oe, 1'b0)
		pulse(7'h01);
		`CHK(o_interrupt_out_n_oe, 1'b1)
		#1 i_oe = 1'b0;
		repeat (6) @(posedge i_ref_clk);
		`CHK({o_data_oe, o_perf_monitor_tick_oe, o_interrupt_out_n_oe, o_gpio_oe}, {3'h0, gpio_en(d, 1'b0)})
		#1 i_oe = 1'b1;
		repeat (6) @(posedge i_ref_clk);
		wr(`OFS_INT_PEND, 8'h01);
		`CHK(o_interrupt_out_n_oe, 1'b0)
		$display("interrupt done");
		wr(`OFS_PM_CTRL, 8'h01);
		count(64);
		`CHK(n, 4)
		`CHK(m, 4)
		`CHK(o_perf_monitor_tick_oe, 1'b1)
		wr(`OFS_PM_CTRL, 8'h02);
		#1 i_perf_monitor_tick = 1'b1;
		count(20);
		`CHK(n, 1)
		`CHK(m, 0)
		$display("tick done");
		@(posedge i_ref_clk);
		#1 i_resetn = 1'b0;
		#1 `CHK(o_gpio_oe, 8'h00)
		repeat (3) @(posedge i_ref_clk);
		#1 i_resetn = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		rd(`OFS_SCRATCH, q);
		`CHK(q, 8'h00)
		$display("reset done");
		close_out();
	end

	initial begin
		#(4 * 20000);
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
